// ==== core/dos_pkg.sv ====
// package: operating states, control word fields, timing constants for the drive state machine
package dos_pkg;
   typedef enum {
      ST_NOT_READY,
      ST_SWITCH_ON_DISABLED,
      ST_READY,
      ST_SWITCHED_ON,
      ST_OP_ENABLED,
      ST_QUICK_STOP,
      ST_FAULT_REACTION,
      ST_FAULT
   } dos_state_type;

   // control word bit positions
   localparam int CW_SWITCH_ON    = 0;
   localparam int CW_ENABLE_VOLT  = 1;
   localparam int CW_QUICK_STOP   = 2;
   localparam int CW_ENABLE_OP    = 3;
   localparam int CW_FAULT_RESET  = 7;
   localparam logic [15:0] CTRL_WORD_RESET = 16'h0000;

   // quick stop behaviour encodings
   localparam logic QS_RAMP_THEN_DISABLE = 1'b0;
   localparam logic QS_RAMP_THEN_HOLD    = 1'b1;
   // disable operation stop encodings
   localparam logic DOS_FREEWHEEL = 1'b0;
   localparam logic DOS_RAMP      = 1'b1;

   // status reported per state
   typedef struct packed {
      logic motor_power;
      logic power_stage_enable;
      logic supply_required;
      logic config_allowed;
      logic reported_valid;
   } dos_status_type;
   // value after reset: configuration allowed, nothing reported yet
   localparam dos_status_type STATUS_RESET = 5'h02;

   // ramp timeout bound for assertions, in cycles
   localparam int RAMP_WAIT_MAX = 1000;
endpackage

// ==== core/dos_cmd_decode.sv ====
// control word decoder: command patterns and fault reset edge
`timescale 1ns/1ns
module dos_cmd_decode
   import dos_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] ctrl_word,
   output logic             cmd_shutdown,
   output logic             cmd_switch_on,
   output logic             cmd_enable_op,
   output logic             cmd_disable_op,
   output logic             cmd_disable_volt,
   output logic             cmd_quick_stop,
   output logic             cmd_fault_reset
);
   logic fault_reset_last;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_reset_last <= 1'b0;
      end else begin
         fault_reset_last <= ctrl_word[CW_FAULT_RESET];
      end
   end

   // shutdown and switch on ignore bit 3
   assign cmd_shutdown     = ctrl_word[CW_QUICK_STOP] & ctrl_word[CW_ENABLE_VOLT]
                             & ~ctrl_word[CW_SWITCH_ON];
   assign cmd_switch_on    = ctrl_word[CW_QUICK_STOP] & ctrl_word[CW_ENABLE_VOLT]
                             & ctrl_word[CW_SWITCH_ON];
   assign cmd_enable_op    = cmd_switch_on & ctrl_word[CW_ENABLE_OP];
   assign cmd_disable_op   = cmd_switch_on & ~ctrl_word[CW_ENABLE_OP];
   assign cmd_disable_volt = ~ctrl_word[CW_ENABLE_VOLT];
   assign cmd_quick_stop   = ctrl_word[CW_ENABLE_VOLT] & ~ctrl_word[CW_QUICK_STOP];
   assign cmd_fault_reset  = ctrl_word[CW_FAULT_RESET] & ~fault_reset_last;
endmodule

// ==== core/dos_state_machine.sv ====
// drive operating state machine: control word register, states, power and config gating
// Behaviour
// - quick stop active holds the drive; restart only via switch on disabled
// - during fast stop the motor stays powered and configuration writes are refused
// - leaving quick stop active is steered by the quick stop behaviour setting
// - ramp then disable: after ramp go to switch on disabled automatically
// - ramp then hold: stay until disable voltage, stop key or freewheel input
// - fault reaction runs the configured error response, then continues
// - fault state: power stage disabled, drive locked, motor unpowered
// - config writes ok in 1,2,3,8; in 4 force disable; refused in 5,6
// - motor power only in operation enabled, fast stop, or per error response
// - supply required in 4,5,6; not in 1,2,3,8; per response in 7
// - rising edge of bit 7 resets fault once cause is gone
// - shutdown 0006 leads to ready; switch on 0007 leads to switched on
// - bit 1 clear disables voltage, going to switch on disabled
// - not ready state is transient and never reported
// - with reference on the channel, enable waits for a received reference
// - disable operation: 0 freewheel to switched on, 1 ramp first
`timescale 1ns/1ns
module dos_state_machine
   import dos_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // control word register port
   input  wire logic        ctrl_write,
   input  wire logic [15:0] ctrl_wdata,
   output logic      [15:0] ctrl_rdata,
   // settings
   input  wire logic        quick_stop_behaviour_select,
   input  wire logic        disable_operation_stop_select,
   input  wire logic        ref_on_command_channel,
   input  wire logic        error_response_powered,
   // configuration write request
   input  wire logic        config_write_req,
   output logic             config_write_accept,
   // local events
   input  wire logic        stop_key,
   input  wire logic        freewheel_input,
   input  wire logic        reference_received,
   input  wire logic        internal_error,
   input  wire logic        error_cause_active,
   input  wire logic        ramp_done,
   input  wire logic        error_response_done,
   // state and outputs
   output dos_state_type    op_state,
   output logic             reported_valid,
   output logic             ramp_active,
   output logic             motor_power,
   output logic             power_stage_enable,
   output logic             supply_required,
   output logic             config_allowed
);
   logic [15:0]   ctrl_word;
   dos_state_type state;
   dos_state_type next_state;
   logic          ref_seen;
   logic          ramping;
   logic          next_ramping;
   logic          cmd_shutdown;
   logic          cmd_switch_on;
   logic          cmd_enable_op;
   logic          cmd_disable_op;
   logic          cmd_disable_volt;
   logic          cmd_quick_stop;
   logic          cmd_fault_reset;
   logic          enable_ok;
   logic          hold_exit;
   dos_status_type status;
   dos_status_type next_status;

   dos_cmd_decode u_decode (
      .clk              (clk),
      .rst_n            (rst_n),
      .ctrl_word        (ctrl_word),
      .cmd_shutdown     (cmd_shutdown),
      .cmd_switch_on    (cmd_switch_on),
      .cmd_enable_op    (cmd_enable_op),
      .cmd_disable_op   (cmd_disable_op),
      .cmd_disable_volt (cmd_disable_volt),
      .cmd_quick_stop   (cmd_quick_stop),
      .cmd_fault_reset  (cmd_fault_reset)
   );

   function automatic logic powered_state(input dos_state_type s);
      powered_state = (s == ST_SWITCHED_ON) || (s == ST_OP_ENABLED) || (s == ST_QUICK_STOP);
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_word <= CTRL_WORD_RESET;
      end else if (ctrl_write) begin
         ctrl_word <= ctrl_wdata;
      end
   end
   assign ctrl_rdata = ctrl_word;

   // reference latch: set wins over nothing, only cleared by reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ref_seen <= 1'b0;
      end else if (reference_received) begin
         ref_seen <= 1'b1;
      end
   end

   assign enable_ok = !ref_on_command_channel || ref_seen;
   assign hold_exit = cmd_disable_volt || stop_key || freewheel_input;
   // configuration writes: accepted in 1,2,3,8 and 4; refused in 5,6,7
   assign config_write_accept = config_write_req && status.config_allowed;

   always_comb begin
      next_state   = state;
      next_ramping = 1'b0;
      case (state)
         ST_NOT_READY: begin
            next_state = ST_SWITCH_ON_DISABLED;
         end
         ST_SWITCH_ON_DISABLED: begin
            if (cmd_shutdown) begin
               next_state = ST_READY;
            end
         end
         ST_READY: begin
            if (cmd_disable_volt || cmd_quick_stop) begin
               next_state = ST_SWITCH_ON_DISABLED;
            end else if (cmd_enable_op && enable_ok) begin
               next_state = ST_OP_ENABLED;
            end else if (cmd_switch_on) begin
               next_state = ST_SWITCHED_ON;
            end
         end
         ST_SWITCHED_ON: begin
            if (internal_error) begin
               next_state = ST_FAULT_REACTION;
            end else if (cmd_disable_volt || cmd_quick_stop || config_write_accept) begin
               next_state = ST_SWITCH_ON_DISABLED;
            end else if (cmd_shutdown) begin
               next_state = ST_READY;
            end else if (cmd_enable_op && enable_ok) begin
               next_state = ST_OP_ENABLED;
            end
         end
         ST_OP_ENABLED: begin
            if (internal_error) begin
               next_state = ST_FAULT_REACTION;
            end else if (cmd_disable_volt) begin
               next_state = ST_SWITCH_ON_DISABLED;
            end else if (cmd_quick_stop) begin
               next_state   = ST_QUICK_STOP;
               next_ramping = 1'b1;
            end else if (cmd_shutdown) begin
               next_state = ST_READY;
            end else if (cmd_disable_op) begin
               // ramp option holds here until the ramp ends
               if (disable_operation_stop_select == DOS_FREEWHEEL || ramp_done) begin
                  next_state = ST_SWITCHED_ON;
               end else begin
                  next_ramping = 1'b1;
               end
            end
         end
         ST_QUICK_STOP: begin
            next_ramping = ramping && !ramp_done;
            if (internal_error) begin
               next_state   = ST_FAULT_REACTION;
               next_ramping = 1'b0;
            end else if (cmd_disable_volt) begin
               next_state   = ST_SWITCH_ON_DISABLED;
               next_ramping = 1'b0;
            end else if (!next_ramping) begin
               if (quick_stop_behaviour_select == QS_RAMP_THEN_DISABLE || hold_exit) begin
                  next_state = ST_SWITCH_ON_DISABLED;
               end
            end
         end
         ST_FAULT_REACTION: begin
            if (error_response_done) begin
               next_state = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (cmd_fault_reset && !error_cause_active) begin
               next_state = ST_SWITCH_ON_DISABLED;
            end
         end
         default: begin
            next_state = ST_NOT_READY;
         end
      endcase
   end

   always_comb begin
      next_status = '0;
      case (next_state)
         ST_NOT_READY:          next_status = 5'b00010;
         ST_SWITCH_ON_DISABLED: next_status = 5'b00011;
         ST_READY:              next_status = 5'b00011;
         ST_SWITCHED_ON:        next_status = 5'b01111;
         ST_OP_ENABLED:         next_status = 5'b11101;
         ST_QUICK_STOP:         next_status = {next_ramping, next_ramping, 3'b101};
         ST_FAULT_REACTION: begin
            next_status = {error_response_powered, error_response_powered,
                           error_response_powered, 2'b01};
         end
         ST_FAULT:              next_status = 5'b00011;
         default:               next_status = 5'b00010;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state   <= ST_NOT_READY;
         ramping <= 1'b0;
         status  <= STATUS_RESET;
      end else begin
         state   <= next_state;
         ramping <= next_ramping;
         status  <= next_status;
      end
   end

   assign op_state           = state;
   assign ramp_active        = ramping;
   assign motor_power        = status.motor_power;
   assign power_stage_enable = status.power_stage_enable;
   assign supply_required    = status.supply_required;
   assign config_allowed     = status.config_allowed;
   assign reported_valid     = status.reported_valid;

   AST_FAULT_UNPOWERED: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_FAULT |-> !motor_power && !power_stage_enable)
      else $error("fault state drives motor");
   AST_CFG_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ST_OP_ENABLED || state == ST_QUICK_STOP) |-> !config_write_accept)
      else $error("config accepted while running");
   AST_NOT_READY_HIDDEN: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_NOT_READY |-> !reported_valid)
      else $error("not ready state reported");
   AST_FAULT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_FAULT && cmd_fault_reset && !error_cause_active
      |=> state == ST_SWITCH_ON_DISABLED)
      else $error("fault reset ignored");
   AST_ERROR_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
      powered_state(state) && internal_error |=> state == ST_FAULT_REACTION)
      else $error("internal error not handled");
   AST_QS_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_OP_ENABLED && !internal_error && cmd_quick_stop && !cmd_disable_volt
      |=> state == ST_QUICK_STOP && ramp_active && motor_power)
      else $error("quick stop entry wrong");
   AST_QS_AUTO_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_QUICK_STOP && ramping && ramp_done && !internal_error
      && quick_stop_behaviour_select == QS_RAMP_THEN_DISABLE
      |=> state == ST_SWITCH_ON_DISABLED)
      else $error("quick stop did not exit");
   AST_QS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_QUICK_STOP && !ramping && !hold_exit && !internal_error
      && quick_stop_behaviour_select == QS_RAMP_THEN_HOLD
      |=> state == ST_QUICK_STOP)
      else $error("quick stop hold left");
   AST_ENABLE_NEEDS_REF: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(state) && state == ST_OP_ENABLED |-> $past(enable_ok))
      else $error("enabled without reference");
   AST_MOTOR_POWER: assert property (@(posedge clk) disable iff (!rst_n)
      motor_power |-> state == ST_OP_ENABLED || (state == ST_QUICK_STOP && ramping)
      || state == ST_FAULT_REACTION)
      else $error("motor powered in wrong state");
   AST_NOT_READY_LEAVES: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_NOT_READY |=> state == ST_SWITCH_ON_DISABLED)
      else $error("not ready state held");
   AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_SWITCH_ON_DISABLED && cmd_shutdown |=> state == ST_READY)
      else $error("shutdown ignored");
   AST_CFG_FORCES_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_SWITCHED_ON && config_write_accept && !internal_error
      |=> state == ST_SWITCH_ON_DISABLED)
      else $error("config write kept switched on");
   AST_REACTION_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_FAULT_REACTION && error_response_done |=> state == ST_FAULT)
      else $error("fault reaction did not end");
   AST_FREEWHEEL_STOP: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_OP_ENABLED && !internal_error && cmd_disable_op
      && disable_operation_stop_select == DOS_FREEWHEEL
      |=> state == ST_SWITCHED_ON && !motor_power)
      else $error("freewheel disable operation wrong");
   AST_SUPPLY_REQUIRED: assert property (@(posedge clk) disable iff (!rst_n)
      powered_state(state) |-> supply_required)
      else $error("supply not required while powered");
   AST_FAST_STOP_POWERED: assert property (@(posedge clk) disable iff (!rst_n)
      state == ST_QUICK_STOP && ramping |-> motor_power && power_stage_enable)
      else $error("fast stop lost power");

   COV_RUN: cover property (@(posedge clk) disable iff (!rst_n)
      state == ST_SWITCHED_ON ##1 state == ST_OP_ENABLED);
   COV_QS: cover property (@(posedge clk) disable iff (!rst_n)
      state == ST_QUICK_STOP ##1 state == ST_SWITCH_ON_DISABLED);
   COV_FAULT: cover property (@(posedge clk) disable iff (!rst_n)
      state == ST_FAULT ##1 state == ST_SWITCH_ON_DISABLED);
   COV_HOLD_EXIT: cover property (@(posedge clk) disable iff (!rst_n)
      state == ST_QUICK_STOP && !ramping && hold_exit ##1 state == ST_SWITCH_ON_DISABLED);
   COV_DISABLE_RAMP: cover property (@(posedge clk) disable iff (!rst_n)
      state == ST_OP_ENABLED && ramping ##1 state == ST_SWITCHED_ON);
endmodule

// ==== sim/dos_master_model.sv ====
// fieldbus master model: writes whole control words, changing them at the falling edge
`timescale 1ns/1ns
module dos_master_model
   import dos_pkg::*;
(
   input  wire logic        clk,
   output logic             ctrl_write,
   output logic      [15:0] ctrl_wdata
);
   initial begin
      ctrl_write = 1'b0;
      ctrl_wdata = CTRL_WORD_RESET;
   end
   task automatic put(input logic [15:0] w);
      @(negedge clk);
      ctrl_write = 1'b1;
      ctrl_wdata = w;
      @(negedge clk);
      ctrl_write = 1'b0;
      // released data shows garbage, so a design that ignores the strobe is caught
      ctrl_wdata = ~w;
   endtask
endmodule

// ==== sim/tb.sv ====
// testbench: control words and events in, operating state scoreboarded
`timescale 1ns/1ns
module tb
   import dos_pkg::*;
;
   typedef struct packed {
      dos_state_type st;
      logic          mp;
   } dos_note_type;
   logic clk, rst_n, ctrl_write, config_write_req, config_write_accept;
   logic [15:0] ctrl_wdata, ctrl_rdata;
   logic quick_stop_behaviour_select, disable_operation_stop_select, ref_on_command_channel;
   logic error_response_powered, stop_key, freewheel_input, reference_received;
   logic internal_error, error_cause_active, ramp_done, error_response_done;
   logic reported_valid, ramp_active, motor_power, power_stage_enable;
   logic supply_required, config_allowed;
   dos_state_type op_state, last_state;
   dos_note_type  notes[$];
   int            errors, cmp_count;

   initial clk = 1'b0;
   always #5 clk = ~clk;

   dos_master_model master (.clk, .ctrl_write, .ctrl_wdata);
   dos_state_machine dut (.clk, .rst_n, .ctrl_write, .ctrl_wdata, .ctrl_rdata,
      .quick_stop_behaviour_select, .disable_operation_stop_select, .ref_on_command_channel,
      .error_response_powered, .config_write_req, .config_write_accept, .stop_key,
      .freewheel_input, .reference_received, .internal_error, .error_cause_active,
      .ramp_done, .error_response_done, .op_state, .reported_valid, .ramp_active,
      .motor_power, .power_stage_enable, .supply_required, .config_allowed);

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (exp !== got) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // bounded wait for the monitor to consume the note
   task automatic expect_st(input dos_state_type st, input logic mp);
      int n;
      n = 0;
      notes.push_back('{st, mp});
      while (notes.size() != 0 && n < 12) begin
         @(negedge clk);
         n++;
      end
      if (notes.size() != 0) begin
         errors++;
         $display("wrong value op_state expected %0d seen %0d", st, op_state);
         test_done();
      end
   endtask
   task automatic cmd(input logic [15:0] w, input dos_state_type st, input logic mp);
      master.put(w);
      expect_st(st, mp);
   endtask
   task automatic keep(input logic [15:0] w);
      dos_state_type st0;
      st0 = op_state;
      master.put(w);
      repeat (3) @(negedge clk);
      chk("op_state", 16'(st0), 16'(op_state));
   endtask
   task automatic cfg(input logic exp);
      config_write_req = 1'b1;
      #1 chk("config_write_accept", 16'(exp), 16'(config_write_accept));
      @(negedge clk);
      config_write_req = 1'b0;
   endtask

   always @(negedge clk) begin
      if (rst_n === 1'b1 && op_state !== last_state) begin
         if (notes.size() == 0) begin
            errors++;
            $display("wrong value op_state expected none seen %0d", op_state);
         end else begin
            chk("op_state", 16'(notes[0].st), 16'(op_state));
            chk("motor_power", 16'(notes[0].mp), 16'(motor_power));
            void'(notes.pop_front());
         end
      end
      last_state = op_state;
   end

   initial begin
      {rst_n, config_write_req, quick_stop_behaviour_select, stop_key} = '0;
      {disable_operation_stop_select, error_response_powered, freewheel_input} = '0;
      {reference_received, internal_error, error_cause_active, ramp_done} = '0;
      error_response_done = 1'b0;
      ref_on_command_channel = 1'b1;
      errors = 0;
      cmp_count = 0;
      void'($urandom(32'he3fc));
      repeat (2) @(negedge clk);
      chk("reported_valid", 16'h0000, 16'(reported_valid));
      rst_n = 1'b1;
      expect_st(ST_SWITCH_ON_DISABLED, 1'b0);
      chk("reported_valid", 16'h0001, 16'(reported_valid));
      cmd(16'h0006, ST_READY, 1'b0);
      // without a reference the enable pattern only switches on
      cmd(16'h000F, ST_SWITCHED_ON, 1'b0);
      keep(16'h000F);
      chk("ctrl_rdata", 16'h000F, ctrl_rdata);
      cmd(16'h0006, ST_READY, 1'b0);
      reference_received = 1'b1;
      @(negedge clk);
      reference_received = 1'b0;
      cmd(16'h000F, ST_OP_ENABLED, 1'b1);
      cfg(1'b0);
      cmd(16'h0007, ST_SWITCHED_ON, 1'b0);
      chk("supply_required", 16'h0001, 16'(supply_required));
      config_write_req = 1'b1;
      #1 chk("config_write_accept", 16'h0001, 16'(config_write_accept));
      expect_st(ST_SWITCH_ON_DISABLED, 1'b0);
      config_write_req = 1'b0;
      $display("test power up and config done");
      cmd(16'h0006, ST_READY, 1'b0);
      cmd(16'h000F, ST_OP_ENABLED, 1'b1);
      disable_operation_stop_select = 1'b1;
      keep(16'h0007);
      chk("ramp_active", 16'h0001, 16'(ramp_active));
      ramp_done = 1'b1;
      expect_st(ST_SWITCHED_ON, 1'b0);
      {ramp_done, disable_operation_stop_select} = '0;
      cmd(16'h0002, ST_SWITCH_ON_DISABLED, 1'b0);
      keep(16'h0007);
      $display("test disable operation done");
      for (int m = 0; m < 4; m++) begin
         quick_stop_behaviour_select = (m != 0);
         cmd(16'h0006, ST_READY, 1'b0);
         cmd(16'h000F, ST_OP_ENABLED, 1'b1);
         cmd(16'h0002, ST_QUICK_STOP, 1'b1);
         chk("ramp_active", 16'h0001, 16'(ramp_active));
         cfg(1'b0);
         ramp_done = 1'b1;
         if (m == 0) begin
            expect_st(ST_SWITCH_ON_DISABLED, 1'b0);
         end else begin
            keep(16'h000F);
            chk("motor_power", 16'h0000, 16'(motor_power));
            stop_key = (m == 1);
            freewheel_input = (m == 2);
            if (m == 3) master.put(16'($urandom) & 16'h000D);
            expect_st(ST_SWITCH_ON_DISABLED, 1'b0);
            {stop_key, freewheel_input} = '0;
         end
         ramp_done = 1'b0;
      end
      $display("test quick stop done");
      error_response_powered = 1'($urandom);
      cmd(16'h0006, ST_READY, 1'b0);
      cmd(16'h000F, ST_OP_ENABLED, 1'b1);
      internal_error = 1'b1;
      expect_st(ST_FAULT_REACTION, error_response_powered);
      internal_error = 1'b0;
      chk("supply_required", 16'(error_response_powered), 16'(supply_required));
      {error_cause_active, error_response_done} = 2'b11;
      expect_st(ST_FAULT, 1'b0);
      error_response_done = 1'b0;
      chk("power_stage_enable", 16'h0000, 16'(power_stage_enable));
      chk("config_allowed", 16'h0001, 16'(config_allowed));
      master.put(16'h0000);
      keep(16'h0080);
      error_cause_active = 1'b0;
      master.put(16'h0000);
      cmd(16'h0080, ST_SWITCH_ON_DISABLED, 1'b0);
      $display("test fault done");
      cmd(16'h0006, ST_READY, 1'b0);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("op_state", 16'(ST_NOT_READY), 16'(op_state));
      chk("reported_valid", 16'h0000, 16'(reported_valid));
      rst_n = 1'b1;
      expect_st(ST_SWITCH_ON_DISABLED, 1'b0);
      cmd(16'h0006, ST_READY, 1'b0);
      cmd(16'h000F, ST_SWITCHED_ON, 1'b0);
      keep(16'h000F);
      $display("test second reset done");
      test_done();
   end
endmodule
